/* inc/cfrs_pkg.sv */
// constants, states and timing figures shared by the clock fanout and reset stretcher
`default_nettype none
package cfrs_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 100;
  localparam int RST_MIN_PULSE_NS = 10;
  // least time rounds up, never below one cycle
  localparam int RST_MIN_PULSE_RAW = (RST_MIN_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int RST_MIN_PULSE_CYC = (RST_MIN_PULSE_RAW < 1) ? 1 : RST_MIN_PULSE_RAW;
  // oscillator tick divider: one tick per TICK_DIV clock cycles
  localparam int TICK_DIV = 1;
  localparam int DIV_W = 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 1'h0;
  localparam logic [DIV_W-1:0] DIV_ONE = 1'h1;
  // ----------------------------------------------------------------
  // oscillator phase: bit0 double rate, bit1 primary, bit2 half rate
  // ----------------------------------------------------------------
  localparam int PH_W = 3;
  localparam int PH_DBL = 0;
  localparam int PH_PRI = 1;
  localparam int PH_HALF = 2;
  localparam logic [PH_W-1:0] PH_ALIGN = 3'h0;
  localparam logic [PH_W-1:0] PH_RELOAD = 3'h1;
  localparam logic [PH_W-1:0] PH_ONE = 3'h1;
  localparam logic [1:0] PH_PRI_WRAP = 2'h3;
  localparam int NUM_PRI = 3;
  // ----------------------------------------------------------------
  // lock detection
  // ----------------------------------------------------------------
  localparam int LOCK_CW = 3;
  localparam logic [LOCK_CW-1:0] LOCK_EDGES = 3'h4;
  localparam logic [LOCK_CW-1:0] LOCK_ONE = 3'h1;
  localparam logic [LOCK_CW-1:0] LOCK_ZERO = 3'h0;
  localparam int WD_W = 5;
  // two feedback periods without a reference edge means lock is gone
  localparam logic [WD_W-1:0] REF_TIMEOUT = WD_W'(2 * 8 * TICK_DIV);
  localparam logic [WD_W-1:0] WD_ONE = 5'h01;
  localparam logic [WD_W-1:0] WD_ZERO = 5'h00;
  // ----------------------------------------------------------------
  // reset stretch
  // ----------------------------------------------------------------
  localparam int STRETCH_CYCLES = 1024;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  typedef enum logic [1:0] {
    ST_LOCKWAIT,
    ST_HOLD,
    ST_STRETCH,
    ST_RUN
  } cfrs_state_t;
endpackage
`default_nettype wire

/* hw/cfrs_clkgen.sv */
// digital oscillator: tick divider and three-bit output phase counter
`default_nettype none
module cfrs_clkgen (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic realign,
  output logic tick,
  output logic [cfrs_pkg::PH_W-1:0] phase
);
  import cfrs_pkg::*;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [PH_W-1:0] phase_reg;
  logic [PH_W-1:0] phase_next;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // a stopped oscillator freezes the phase, so outputs stay static
  always_comb begin
    div_next = div_reg;
    phase_next = phase_reg;
    tick = run && (div_reg == DIV_LAST);
    if (realign) begin
      // snap to the reference edge; this cycle counts as phase zero
      div_next = DIV_ZERO;
      phase_next = PH_RELOAD;
    end else if (run) begin
      if (tick) begin
        div_next = DIV_ZERO;
        phase_next = phase_reg + PH_ONE;
      end else begin
        div_next = div_reg + DIV_ONE;
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      div_reg <= DIV_ZERO;
      phase_reg <= PH_ALIGN;
    end else begin
      div_reg <= div_next;
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;
endmodule
`default_nettype wire

/* hw/cfrs_top.sv */
// clock fanout with lock detection, test mode and open-drain reset stretcher
`default_nettype none
module cfrs_top (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic SYNC,
  input wire logic PLL_EN,
  input wire logic RST_REQ_N,
  output logic [cfrs_pkg::NUM_PRI-1:0] PRIMARY_CLOCK_OUTPUTS,
  output logic INVERTED_CLOCK_OUT,
  output logic DOUBLE_RATE_CLOCK_OUT,
  output logic HALF_RATE_CLOCK_OUT,
  output logic LOCK_RST_N_O,
  output logic LOCK_RST_N_OE
);
  import cfrs_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic tick;
  logic [PH_W-1:0] phase;
  logic realign;
  logic ref_rise;
  logic pri_edge;
  logic sync_d_reg;
  logic sync_d_next;
  logic locked_reg;
  logic locked_next;
  logic [LOCK_CW-1:0] good_reg;
  logic [LOCK_CW-1:0] good_next;
  logic [WD_W-1:0] wd_reg;
  logic [WD_W-1:0] wd_next;
  logic [NUM_PRI-1:0] pri_reg;
  logic [NUM_PRI-1:0] pri_next;
  logic inv_reg;
  logic inv_next;
  logic dbl_reg;
  logic dbl_next;
  logic half_reg;
  logic half_next;
  logic tst_half_reg;
  logic tst_half_next;
  cfrs_state_t st_reg;
  cfrs_state_t st_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic oe_reg;
  logic oe_next;
  logic od_reg;

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  // the whole three-bit phase is the feedback that the lock loop compares against zero
  cfrs_clkgen u_clkgen (
    .clk(MCLK),
    .srst(SRST),
    .run(PLL_EN),
    .realign(realign),
    .tick(tick),
    .phase(phase)
  );

  // ----------------------------------------------------------------
  // reference edge and lock detection
  // ----------------------------------------------------------------
  // reference is sampled directly; a rise is seen on the first edge that samples it high,
  // so the feedback phase target is zero, with no delay to absorb
  assign ref_rise = SYNC && !sync_d_reg;
  // misaligned feedback forces the oscillator back onto the reference
  assign realign = PLL_EN && ref_rise && (phase != PH_ALIGN);
  // a primary rising edge is the phase wrapping past three in its low bits
  assign pri_edge = tick && (phase[PH_PRI:PH_DBL] == PH_PRI_WRAP);

  // lock needs a run of aligned edges; any miss or timeout drops it
  always_comb begin
    sync_d_next = SYNC;
    locked_next = locked_reg;
    good_next = good_reg;
    wd_next = wd_reg;
    if (!PLL_EN) begin
      // test mode: no loop, so no lock is claimed
      locked_next = 1'b0;
      good_next = LOCK_ZERO;
      wd_next = WD_ZERO;
    end else if (ref_rise) begin
      wd_next = WD_ZERO;
      if (realign) begin
        locked_next = 1'b0;
        good_next = LOCK_ZERO;
      end else if (good_reg == LOCK_EDGES) begin
        locked_next = 1'b1;
      end else begin
        good_next = good_reg + LOCK_ONE;
      end
    end else if (wd_reg == REF_TIMEOUT) begin
      // reference vanished or runs too slow for the loop
      locked_next = 1'b0;
      good_next = LOCK_ZERO;
    end else begin
      wd_next = wd_reg + WD_ONE;
    end
  end

  // lock registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sync_d_reg <= 1'b0;
      locked_reg <= 1'b0;
      good_reg <= LOCK_ZERO;
      wd_reg <= WD_ZERO;
    end else begin
      sync_d_reg <= sync_d_next;
      locked_reg <= locked_next;
      good_reg <= good_next;
      wd_reg <= wd_next;
    end
  end

  // ----------------------------------------------------------------
  // clock outputs
  // ----------------------------------------------------------------
  // primary, double and half rate outputs rise and the inverted one falls when the phase returns to zero; test mode
  // passes the reference straight through, halved on the half rate output, so any input rate up to half of MCLK works
  always_comb begin
    tst_half_next = tst_half_reg;
    if (PLL_EN) begin
      pri_next = {NUM_PRI{~phase[PH_PRI]}};
      inv_next = phase[PH_PRI];
      dbl_next = ~phase[PH_DBL];
      half_next = ~phase[PH_HALF];
    end else begin
      if (ref_rise) begin
        tst_half_next = ~tst_half_reg;
      end
      pri_next = {NUM_PRI{SYNC}};
      inv_next = ~SYNC;
      dbl_next = SYNC;
      half_next = tst_half_reg;
    end
  end

  // one flop per primary output keeps their skew identical
  genvar g;
  generate
    for (g = 0; g < NUM_PRI; g++) begin : g_pri
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          pri_reg[g] <= 1'b0;
        end else begin
          pri_reg[g] <= pri_next[g];
        end
      end
    end
  endgenerate

  // remaining clock registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      inv_reg <= 1'b1;
      dbl_reg <= 1'b0;
      half_reg <= 1'b0;
      tst_half_reg <= 1'b0;
    end else begin
      inv_reg <= inv_next;
      dbl_reg <= dbl_next;
      half_reg <= half_next;
      tst_half_reg <= tst_half_next;
    end
  end

  // ----------------------------------------------------------------
  // reset stretcher
  // ----------------------------------------------------------------
  // the request is sampled once per cycle: a low shorter than one clock
  // period can be missed, so the far side must stretch it to a full cycle
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      ST_LOCKWAIT: begin
        if (!RST_REQ_N) begin
          st_next = ST_HOLD;
        end else if (locked_reg) begin
          st_next = ST_STRETCH;
          cnt_next = CNT_ZERO;
        end
      end
      ST_HOLD: begin
        if (RST_REQ_N && locked_reg) begin
          st_next = ST_STRETCH;
          cnt_next = CNT_ZERO;
        end else if (RST_REQ_N) begin
          st_next = ST_LOCKWAIT;
        end
      end
      ST_STRETCH: begin
        if (!RST_REQ_N) begin
          st_next = ST_HOLD;
        end else if (!locked_reg) begin
          st_next = ST_LOCKWAIT;
        end else if (pri_edge) begin
          if (cnt_reg == STRETCH_LAST) begin
            st_next = ST_RUN;
          end else begin
            cnt_next = cnt_reg + CNT_ONE;
          end
        end
      end
      ST_RUN: begin
        if (!RST_REQ_N) begin
          st_next = ST_HOLD;
        end else if (!locked_reg) begin
          st_next = ST_LOCKWAIT;
        end
      end
    endcase
    // the pin is pulled low in every state but the released one
    oe_next = (st_next != ST_RUN);
  end

  // stretcher registers; the data bit never drives high, the pull-up does
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_reg <= ST_LOCKWAIT;
      cnt_reg <= CNT_ZERO;
      oe_reg <= 1'b1;
      od_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      oe_reg <= oe_next;
      od_reg <= 1'b0;
    end
  end

  assign PRIMARY_CLOCK_OUTPUTS = pri_reg;
  assign INVERTED_CLOCK_OUT = inv_reg;
  assign DOUBLE_RATE_CLOCK_OUT = dbl_reg;
  assign HALF_RATE_CLOCK_OUT = half_reg;
  assign LOCK_RST_N_O = od_reg;
  assign LOCK_RST_N_OE = oe_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  // loop running steadily for the output pipeline depth
  // reset holds the outputs still, so the first edges after it are left out
  sequence run_steady_s;
    PLL_EN && $past(PLL_EN) && $past(PLL_EN, 2) && !$past(SRST) && !$past(SRST, 2);
  endsequence

  // a primary rise followed by four locked cycles
  sequence locked_period_s;
    $rose(PRIMARY_CLOCK_OUTPUTS[0]) && locked_reg ##1 (locked_reg && PLL_EN) [*4];
  endsequence

  // the stretch ending on its last primary edge
  sequence stretch_done_s;
    st_reg == ST_STRETCH && RST_REQ_N && locked_reg && pri_edge && cnt_reg == STRETCH_LAST;
  endsequence

  pri_equal_a: assert property (PRIMARY_CLOCK_OUTPUTS == {NUM_PRI{PRIMARY_CLOCK_OUTPUTS[0]}})
    else $error("primary clocks differ");

  lock_drop_a: assert property (PLL_EN && ref_rise && phase != PH_ALIGN |=> !locked_reg)
    else $error("lock kept on misaligned reference");

  inv_compl_a: assert property (INVERTED_CLOCK_OUT == !PRIMARY_CLOCK_OUTPUTS[0])
    else $error("inverted clock not complement");

  dbl_toggle_a: assert property (run_steady_s and ($past(tick, 2) && !$past(realign, 2))
    |-> DOUBLE_RATE_CLOCK_OUT != $past(DOUBLE_RATE_CLOCK_OUT))
    else $error("double rate clock missed a toggle");

  // a realign jump is not a wrap, so the half edge it makes stands alone
  half_align_a: assert property (run_steady_s and ($rose(HALF_RATE_CLOCK_OUT) && !$past(realign, 2))
    |-> $rose(PRIMARY_CLOCK_OUTPUTS[0]) && $rose(DOUBLE_RATE_CLOCK_OUT))
    else $error("half rate edge not aligned");

  pri_period_a: assert property (locked_period_s |-> $rose(PRIMARY_CLOCK_OUTPUTS[0]))
    else $error("primary period wrong while locked");

  test_pass_a: assert property (!PLL_EN |=> PRIMARY_CLOCK_OUTPUTS == {NUM_PRI{$past(SYNC)}}
    && phase == $past(phase) && !locked_reg)
    else $error("test mode not static pass-through");

  unlock_low_a: assert property (!locked_reg |=> LOCK_RST_N_OE)
    else $error("reset released without lock");

  release_end_a: assert property ($fell(LOCK_RST_N_OE) |-> $past(cnt_reg) == STRETCH_LAST
    && $past(pri_edge) && $past(st_reg) == ST_STRETCH)
    else $error("reset released before full count");

  stretch_end_a: assert property (stretch_done_s |=> !LOCK_RST_N_OE && st_reg == ST_RUN)
    else $error("reset not released after full count");

  open_drain_a: assert property (LOCK_RST_N_O == 1'b0)
    else $error("reset pin driven high");

  req_low_a: assert property (!RST_REQ_N |=> LOCK_RST_N_OE ##1 LOCK_RST_N_OE)
    else $error("reset not held during request");

  restart_a: assert property (st_reg == ST_STRETCH && !RST_REQ_N |=> st_reg == ST_HOLD)
    else $error("request during stretch not restarting");

  count_clear_a: assert property (st_reg == ST_HOLD && RST_REQ_N && locked_reg
    |=> st_reg == ST_STRETCH && cnt_reg == CNT_ZERO)
    else $error("stretch count not cleared");
endmodule
`default_nettype wire

/* tb/cfrs_cpu_model.sv */
// processor-side model: pull-up on the reset line and a clock counter while held in reset
`default_nettype none
module cfrs_cpu_model (
  input wire logic clk,
  input wire logic [cfrs_pkg::NUM_PRI-1:0] pri_clk,
  input wire logic rst_o,
  input wire logic rst_oe,
  output logic rst_line,
  output int rst_clk_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  import cfrs_pkg::*;
  int run_cnt = 0;
  logic pri_q = 1'b0;
  initial rst_clk_cnt = 0;
  // open-drain line: low only while enabled, otherwise the pull-up wins
  assign rst_line = rst_oe ? rst_o : 1'b1;
  // a processor in reset still needs its clock, so count rises while low
  always @(posedge clk) begin
    pri_q <= pri_clk[0];
    if (rst_line === 1'b0) begin
      if (pri_clk[0] === 1'b1 && pri_q === 1'b0) run_cnt <= run_cnt + 1;
    end else begin
      if (run_cnt != 0) rst_clk_cnt <= run_cnt;
      run_cnt <= 0;
    end
  end
endmodule
`default_nettype wire

/* tb/clock_fanout_reset_stretcher_tb_top.sv */
// self-checking bench for the clock fanout and reset stretcher
`default_nettype none
module clock_fanout_reset_stretcher_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cfrs_pkg::*;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic SYNC = 1'b0;
  logic PLL_EN = 1'b1;
  logic RST_REQ_N = 1'b1;
  logic [NUM_PRI-1:0] pri;
  logic inv, dbl, half, rst_o, rst_oe, rst_line;
  int rst_clk_cnt;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int sync_per = 8;
  int sync_ph = 0;
  cfrs_top dut (.MCLK(MCLK), .SRST(SRST), .SYNC(SYNC), .PLL_EN(PLL_EN), .RST_REQ_N(RST_REQ_N),
    .PRIMARY_CLOCK_OUTPUTS(pri), .INVERTED_CLOCK_OUT(inv), .DOUBLE_RATE_CLOCK_OUT(dbl),
    .HALF_RATE_CLOCK_OUT(half), .LOCK_RST_N_O(rst_o), .LOCK_RST_N_OE(rst_oe));
  cfrs_cpu_model cpu (.clk(MCLK), .pri_clk(pri), .rst_o(rst_o), .rst_oe(rst_oe), .rst_line(rst_line),
    .rst_clk_cnt(rst_clk_cnt));
  // ----------------------------------------------------------------
  // clock, reference and hang guard
  // ----------------------------------------------------------------
  initial forever #50 MCLK = ~MCLK;
  // reference rises where the phase counter wraps; half high, half low
  always @(negedge MCLK) begin
    sync_ph <= (sync_ph + 1) % sync_per;
    SYNC <= ((sync_ph + 1) % sync_per) < (sync_per / 2);
  end
  // ceiling well above the roughly 30000 cycles the scenarios need
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // inputs change just after the falling edge, outputs are settled there
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge MCLK);
      #1;
    end
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask
  // bounded wait for the pull-up to win, measured from a start cycle
  task automatic wait_release(input int start, input int lo, input int hi);
    while (rst_line !== 1'b1 && (cyc - start) <= hi) tick(1);
    in_range(cyc - start, lo, hi);
  endtask
  task automatic do_reset();
    SRST = 1'b1;
    tick(12);
    SRST = 1'b0;
  endtask
  // one full cycle low is exactly the least pulse the far side must give
  task automatic request(output int start);
    RST_REQ_N = 1'b0;
    tick(1);
    RST_REQ_N = 1'b1;
    start = cyc;
  endtask
  // locked waveforms against the reference, cycle by cycle over a period
  task automatic check_clocks(input int nper);
    logic p;
    repeat (nper) begin
      // outputs rise just after the first edge that sees the reference high
      while (sync_ph != 0) tick(1);
      for (int c = 2; c < 10; c++) begin
        tick(1);
        p = ((c - 2) % 4) < 2;
        check({pri, inv}, {{NUM_PRI{p}}, ~p});
        check(dbl, (c % 2) == 0);
        check(half, ((c - 2) % 8) < 4);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    int t0;
    do_reset();
    t0 = cyc;
    tick(2);
    check(rst_line, 1'b0);
    tick(4000);
    check(rst_line, 1'b0);
    wait_release(t0, 4136, 4300);
    check_clocks(4);
  endtask
  task automatic t_request();
    int t0;
    request(t0);
    check(rst_line, 1'b0);
    check_clocks(4);
    check(rst_line, 1'b0);
    wait_release(t0, 4094, 4097);
    tick(4);
    in_range(rst_clk_cnt, 1024, 1026);
  endtask
  task automatic t_restart();
    int t0;
    request(t0);
    tick(2000);
    request(t0);
    tick(1000);
    check(rst_line, 1'b0);
    wait_release(t0, 4094, 4097);
  endtask
  task automatic t_held_low();
    int highs;
    highs = 0;
    RST_REQ_N = 1'b0;
    do_reset();
    repeat (5000) begin
      tick(1);
      if (rst_line !== 1'b0) highs++;
    end
    check(highs, 0);
    RST_REQ_N = 1'b1;
    wait_release(cyc, 4094, 4097);
  endtask
  // slow reference with the loop off: outputs follow it, no internal rate
  task automatic t_test_mode();
    int bad, pri_up, half_up;
    logic p_q, h_q;
    bad = 0;
    pri_up = 0;
    half_up = 0;
    PLL_EN = 1'b0;
    sync_per = 20;
    tick(30);
    p_q = pri[0];
    h_q = half;
    repeat (200) begin
      tick(1);
      if (pri !== {NUM_PRI{pri[0]}} || inv !== ~pri[0] || dbl !== pri[0] || rst_line !== 1'b0) bad++;
      if (pri[0] === 1'b1 && p_q === 1'b0) pri_up++;
      if (half === 1'b1 && h_q === 1'b0) half_up++;
      p_q = pri[0];
      h_q = half;
    end
    check(bad, 0);
    in_range(pri_up, 9, 11);
    in_range(half_up, 4, 6);
    PLL_EN = 1'b1;
    sync_per = 8;
    wait_release(cyc, 4096, 4400);
    check_clocks(2);
  endtask
  // ----------------------------------------------------------------
  // main sequence and verdict
  // ----------------------------------------------------------------
  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    t_power_up();
    t_request();
    t_restart();
    t_held_low();
    t_test_mode();
    summarize();
  end
endmodule
`default_nettype wire
